// file: src/oms_mode_select.sv
/*
 * Operating mode select: catches mode pins at reset release, decodes the
 * mode, keeps the writable mode and emulation bits, drives port, map, debug
 * and narrow-bus address control.
 * Assumes the core supplies register write strobes on this clock and that
 * mode pins come from outside and need synchronising.
 */
`timescale 1ns/100ps
module oms_mode_select (
    input wire logic clk, // 200 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic background_pin, // debug pin level
    input wire logic mode_select_b, // mode pin b
    input wire logic mode_select_a, // mode pin a
    input wire logic mode_wr, // write strobe for mode bits
    input wire oms_pkg::oms_bits_s mode_wdata, // mode bits to write
    input wire logic emul_wr, // write strobe for port e emulation bit
    input wire logic emul_wdata, // port e emulation value
    input wire logic bdm_enable_cmd, // debug enable command seen
    input wire logic bdm_activate, // debug activate request
    input wire logic xfer_start, // external transfer start
    input wire logic xfer_wide, // 16-bit datum requested
    input wire logic [15:0] xfer_addr, // transfer address
    output oms_pkg::oms_bits_s mode_bits, // current mode status bits
    output logic port_e_emulation, // port e emulation bit
    output oms_pkg::oms_cfg_s cfg, // decoded configuration
    output logic background_debug, // debug active
    output logic periph_master, // external master owns bus
    output logic [15:0] bus_addr, // address driven on ports
    output logic bus_high_byte // current narrow cycle is high byte
);
    // pin synchronisers
    logic [2:0] sync1_reg, sync2_reg, sync3_reg;
    logic [2:0] sync1_next, sync2_next, sync3_next;
    logic [2:0] pins_stable_reg, pins_stable_next;
    // mode state
    oms_pkg::oms_bits_s mode_reg, mode_next;
    logic emul_reg, emul_next;
    logic in_reset_reg, in_reset_next;
    logic mode_wr_seen_reg, mode_wr_seen_next;
    logic emul_wr_seen_reg, emul_wr_seen_next;
    logic mode_locked_reg, mode_locked_next;
    logic emul_locked_reg, emul_locked_next;
    logic bdm_en_reg, bdm_en_next;
    logic bdm_reg, bdm_next;
    oms_pkg::oms_cfg_s cfg_reg, cfg_next;
    logic periph_reg, periph_next;
    logic [15:0] addr_reg, addr_next;
    logic hi_reg, hi_next;
    logic second_reg, second_next;

    function automatic oms_pkg::oms_mode_e decode(input oms_pkg::oms_bits_s b);
        oms_pkg::oms_mode_e m;
        m = oms_pkg::oms_mode_e'({b.special_mode_n, b.mode_select_b, b.mode_select_a});
        if (m == oms_pkg::OMS_RESERVED) begin
            m = oms_pkg::OMS_SPECIAL_PERIPH;
        end
        return m;
    endfunction

    function automatic oms_pkg::oms_cfg_s build_cfg(input oms_pkg::oms_mode_e m,
                                                     input logic emul);
        oms_pkg::oms_cfg_s c;
        c = '0;
        c.protect = (m == oms_pkg::OMS_NORMAL_SINGLE) || (m == oms_pkg::OMS_NORMAL_NARROW)
                    || (m == oms_pkg::OMS_NORMAL_WIDE);
        c.core_active = 1'b1;
        c.map_port_ab = 1'b1;
        c.map_port_e = 1'b1;
        case (m)
            oms_pkg::OMS_SPECIAL_SINGLE, oms_pkg::OMS_NORMAL_SINGLE: begin
                c.port_a_use = oms_pkg::OMS_PORT_GPIO;
                c.port_b_use = oms_pkg::OMS_PORT_GPIO;
            end
            oms_pkg::OMS_SPECIAL_NARROW, oms_pkg::OMS_NORMAL_NARROW: begin
                c.port_a_use = oms_pkg::OMS_PORT_ADDR_DATA;
                c.port_b_use = oms_pkg::OMS_PORT_ADDR;
                c.ext_bus = 1'b1;
                c.narrow_bus = 1'b1;
                c.map_port_ab = 1'b0;
                c.map_port_e = !emul;
            end
            oms_pkg::OMS_SPECIAL_WIDE, oms_pkg::OMS_NORMAL_WIDE: begin
                c.port_a_use = oms_pkg::OMS_PORT_ADDR_DATA;
                c.port_b_use = oms_pkg::OMS_PORT_ADDR_DATA;
                c.ext_bus = 1'b1;
                c.map_port_ab = 1'b0;
                c.map_port_e = !emul;
            end
            default: begin
                c.port_a_use = oms_pkg::OMS_PORT_ADDR_DATA;
                c.port_b_use = oms_pkg::OMS_PORT_ADDR_DATA;
                c.ext_bus = 1'b1;
                c.map_port_ab = 1'b0;
                c.map_port_e = 1'b0;
                c.core_active = 1'b0;
            end
        endcase
        return c;
    endfunction

    // synchroniser: change counts once stages two and three agree
    always_comb begin
        sync1_next = {background_pin, mode_select_b, mode_select_a};
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        pins_stable_next = (sync2_reg == sync3_reg) ? sync3_reg : pins_stable_reg;
    end

    always_ff @(posedge clk) begin
        sync1_reg <= sync1_next;
        sync2_reg <= sync2_next;
        sync3_reg <= sync3_next;
        pins_stable_reg <= pins_stable_next;
    end

    // mode, emulation and debug state
    always_comb begin
        oms_pkg::oms_mode_e cur;
        oms_pkg::oms_mode_e req;
        cur = decode(mode_reg);
        req = decode(mode_wdata);
        mode_next = mode_reg;
        emul_next = emul_reg;
        mode_wr_seen_next = mode_wr_seen_reg;
        emul_wr_seen_next = emul_wr_seen_reg;
        mode_locked_next = mode_locked_reg;
        emul_locked_next = emul_locked_reg;
        bdm_en_next = bdm_en_reg;
        bdm_next = bdm_reg;
        in_reset_next = 1'b0;
        if (in_reset_reg) begin
            mode_next = pins_stable_reg;
            emul_next = pins_stable_reg[2] ? oms_pkg::OMS_EMUL_RESET_NORMAL
                                           : oms_pkg::OMS_EMUL_RESET_SPECIAL;
            bdm_next = (decode(pins_stable_reg) == oms_pkg::OMS_SPECIAL_SINGLE);
            bdm_en_next = bdm_next;
        end else begin
            if (mode_wr && cur != oms_pkg::OMS_SPECIAL_PERIPH) begin
                if (mode_reg.special_mode_n) begin
                    if (!mode_locked_reg) begin
                        mode_locked_next = 1'b1;
                        if (req != oms_pkg::OMS_SPECIAL_PERIPH && mode_wdata.special_mode_n) begin
                            mode_next.mode_select_b = mode_wdata.mode_select_b;
                            mode_next.mode_select_a = mode_wdata.mode_select_a;
                        end
                    end
                end else if (!mode_wr_seen_reg) begin
                    mode_wr_seen_next = 1'b1;
                end else if (req != oms_pkg::OMS_SPECIAL_PERIPH) begin
                    mode_next = mode_wdata;
                end
            end
            if (emul_wr) begin
                if (mode_reg.special_mode_n) begin
                    if (!emul_locked_reg) begin
                        emul_locked_next = 1'b1;
                        emul_next = emul_wdata;
                    end
                end else if (!emul_wr_seen_reg) begin
                    emul_wr_seen_next = 1'b1;
                end else begin
                    emul_next = emul_wdata;
                end
            end
            if (bdm_enable_cmd && cur != oms_pkg::OMS_SPECIAL_PERIPH) begin
                bdm_en_next = 1'b1;
            end
            if (bdm_activate && bdm_en_reg && cur != oms_pkg::OMS_SPECIAL_PERIPH) begin
                bdm_next = 1'b1;
            end
        end
        cfg_next = build_cfg(decode(mode_next), emul_next);
        periph_next = (decode(mode_next) == oms_pkg::OMS_SPECIAL_PERIPH);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= oms_pkg::OMS_MODE_BITS_RESET;
            emul_reg <= oms_pkg::OMS_EMUL_RESET_SPECIAL;
            in_reset_reg <= 1'b1;
            mode_wr_seen_reg <= 1'b0;
            emul_wr_seen_reg <= 1'b0;
            mode_locked_reg <= 1'b0;
            emul_locked_reg <= 1'b0;
            bdm_en_reg <= 1'b0;
            bdm_reg <= 1'b0;
            cfg_reg <= '0;
            periph_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            emul_reg <= emul_next;
            in_reset_reg <= in_reset_next;
            mode_wr_seen_reg <= mode_wr_seen_next;
            emul_wr_seen_reg <= emul_wr_seen_next;
            mode_locked_reg <= mode_locked_next;
            emul_locked_reg <= emul_locked_next;
            bdm_en_reg <= bdm_en_next;
            bdm_reg <= bdm_next;
            cfg_reg <= cfg_next;
            periph_reg <= periph_next;
        end
    end

    // narrow bus sequencing: high byte then low byte at address plus one
    always_comb begin
        addr_next = addr_reg;
        hi_next = hi_reg;
        second_next = 1'b0;
        if (second_reg) begin
            addr_next = addr_reg + 16'h0001;
            hi_next = 1'b0;
        end else if (xfer_start && cfg_reg.ext_bus && cfg_reg.core_active) begin
            addr_next = xfer_addr;
            hi_next = cfg_reg.narrow_bus && xfer_wide;
            second_next = cfg_reg.narrow_bus && xfer_wide;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= 16'h0000;
            hi_reg <= 1'b0;
            second_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            hi_reg <= hi_next;
            second_reg <= second_next;
        end
    end

    assign mode_bits = mode_reg;
    assign port_e_emulation = emul_reg;
    assign cfg = cfg_reg;
    assign background_debug = bdm_reg;
    assign periph_master = periph_reg;
    assign bus_addr = addr_reg;
    assign bus_high_byte = hi_reg;
endmodule

// file: src/oms_pkg.sv
/*
 * Constants and types for the operating mode select block.
 * Assumes one 200 MHz clock domain and a synchronous active-low reset.
 */
package oms_pkg;

    typedef enum logic [2:0] {
        OMS_SPECIAL_SINGLE = 3'h0,
        OMS_SPECIAL_NARROW = 3'h1,
        OMS_SPECIAL_PERIPH = 3'h2,
        OMS_SPECIAL_WIDE = 3'h3,
        OMS_NORMAL_SINGLE = 3'h4,
        OMS_NORMAL_NARROW = 3'h5,
        OMS_RESERVED = 3'h6,
        OMS_NORMAL_WIDE = 3'h7
    } oms_mode_e;

    typedef enum logic [1:0] {
        OMS_PORT_GPIO = 2'h0,
        OMS_PORT_ADDR = 2'h1,
        OMS_PORT_ADDR_DATA = 2'h2
    } oms_port_e;

    typedef struct packed {
        logic special_mode_n;
        logic mode_select_b;
        logic mode_select_a;
    } oms_bits_s;

    typedef struct packed {
        oms_port_e port_a_use;
        oms_port_e port_b_use;
        logic ext_bus;
        logic narrow_bus;
        logic map_port_ab;
        logic map_port_e;
        logic protect;
        logic core_active;
    } oms_cfg_s;

    localparam logic [2:0] OMS_MODE_BITS_RESET = 3'h0;
    localparam logic OMS_EMUL_RESET_SPECIAL = 1'h1;
    localparam logic OMS_EMUL_RESET_NORMAL = 1'h0;
    localparam int OMS_SYNC_STAGES = 3;

endpackage

// file: testbench/oms_ext_model.sv
/* Tester on the expansion bus: straps the mode pins, notes high bytes.
   Assumes the bench sets the strap before reset and holds it. */
`timescale 1ns/100ps
module oms_ext_model (
    input logic clk, // clock
    input logic [2:0] strap, // wanted mode code
    input logic [15:0] bus_addr, // device address
    input logic bus_high_byte, // high byte cycle
    output logic background_pin, // debug pin
    output logic mode_select_b, // mode pin b
    output logic mode_select_a, // mode pin a
    output logic [15:0] hi_addr // last high byte address
);
    assign {background_pin, mode_select_b, mode_select_a} = strap;
    always_ff @(posedge clk) if (bus_high_byte) hi_addr <= bus_addr;
endmodule

// file: testbench/oms_mode_select_monitor.sv
/* Checker on the mode select ports.
   Assumes a bind from the bench top, one clock, sync active-low reset. */
`timescale 1ns/100ps
module oms_mode_select_monitor (
    input logic clk, // clock
    input logic rst_n, // reset, active low
    input logic xfer_start, // transfer start
    input logic xfer_wide, // wide datum
    input logic [15:0] xfer_addr, // transfer address
    input oms_pkg::oms_bits_s mode_bits, // mode bits
    input logic port_e_emulation, // emulation bit
    input oms_pkg::oms_cfg_s cfg, // configuration
    input logic background_debug, // debug active
    input logic periph_master, // external master
    input logic [15:0] bus_addr, // bus address
    input logic bus_high_byte // high byte cycle
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic live_reg;
    logic single;
    logic periph;
    // outputs still hold reset values on the release edge
    always_ff @(posedge clk) live_reg <= rst_n;
    assign single = !mode_bits.mode_select_b && !mode_bits.mode_select_a;
    assign periph = mode_bits.mode_select_b && !mode_bits.mode_select_a;
    sequence s_req;
        xfer_start && xfer_wide && cfg.narrow_bus && !bus_high_byte;
    endsequence
    sequence s_high(logic [15:0] a);
        bus_high_byte && bus_addr == a;
    endsequence
    sequence s_low(logic [15:0] a);
        !bus_high_byte && bus_addr == a + 16'h0001;
    endsequence
    property p_narrow;
        logic [15:0] a;
        (s_req, a = xfer_addr) |=> s_high(a) ##1 s_low(a);
    endproperty
    a_single_gpio: assert property (live_reg && single |-> !cfg.ext_bus
        && cfg.port_a_use == oms_pkg::OMS_PORT_GPIO && cfg.port_b_use == oms_pkg::OMS_PORT_GPIO)
        else $error("single-chip port use wrong");
    a_wide_mux: assert property (live_reg && mode_bits.mode_select_b |->
        cfg.port_a_use == oms_pkg::OMS_PORT_ADDR_DATA && cfg.port_b_use == oms_pkg::OMS_PORT_ADDR_DATA)
        else $error("wide port use wrong");
    a_narrow_ports: assert property (live_reg && !mode_bits.mode_select_b
        && mode_bits.mode_select_a |-> cfg.narrow_bus && cfg.port_b_use == oms_pkg::OMS_PORT_ADDR)
        else $error("narrow port use wrong");
    a_narrow_incr: assert property (p_narrow) else $error("narrow byte order wrong");
    a_map_ab: assert property (live_reg |-> cfg.map_port_ab == single)
        else $error("port a b map wrong");
    a_map_e: assert property (live_reg |-> cfg.map_port_e ==
        !(periph || (mode_bits.mode_select_a && port_e_emulation))) else $error("port e map wrong");
    a_protect_level: assert property (live_reg && !periph |->
        cfg.protect == mode_bits.special_mode_n) else $error("protection wrong");
    a_periph_core: assert property (live_reg |-> periph_master == periph
        && cfg.core_active == !periph) else $error("core activity wrong");
    a_debug_entry: assert property (!$past(rst_n, 2) && $past(rst_n)
        && mode_bits == 3'h0 |-> background_debug) else $error("debug not active");
    a_periph_hold: assert property (live_reg && periph_master |=>
        periph_master && $stable(mode_bits)) else $error("peripheral mode left");
    a_normal_stays: assert property (live_reg && mode_bits.special_mode_n |=>
        mode_bits.special_mode_n) else $error("normal mode left");
endmodule

// file: testbench/tb_top.sv
/* Bench top: straps every mode, resets, checks ports, bus bytes, writes.
   Assumes the design, model and monitor are compiled ahead of it. */
`timescale 1ns/100ps
module tb_top;
    logic clk, rst_n, mode_wr, emul_wr, emul_wdata, bdm_enable_cmd, bdm_activate;
    logic xfer_start, xfer_wide, background_pin, mode_select_b, mode_select_a;
    logic port_e_emulation, background_debug, periph_master, bus_high_byte;
    logic [2:0] strap;
    logic [15:0] xfer_addr, bus_addr, hi_addr;
    oms_pkg::oms_bits_s mode_wdata, mode_bits;
    oms_pkg::oms_cfg_s cfg;
    int fail_count = 0;
    int checks_done = 0;
    oms_ext_model u_ext (.clk(clk), .strap(strap), .bus_addr(bus_addr),
        .bus_high_byte(bus_high_byte), .background_pin(background_pin),
        .mode_select_b(mode_select_b), .mode_select_a(mode_select_a), .hi_addr(hi_addr));
    oms_mode_select DUT (.clk(clk), .rst_n(rst_n), .background_pin(background_pin),
        .mode_select_b(mode_select_b), .mode_select_a(mode_select_a), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .emul_wr(emul_wr), .emul_wdata(emul_wdata),
        .bdm_enable_cmd(bdm_enable_cmd), .bdm_activate(bdm_activate),
        .xfer_start(xfer_start), .xfer_wide(xfer_wide), .xfer_addr(xfer_addr),
        .mode_bits(mode_bits), .port_e_emulation(port_e_emulation), .cfg(cfg),
        .background_debug(background_debug), .periph_master(periph_master),
        .bus_addr(bus_addr), .bus_high_byte(bus_high_byte));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic start(input logic [2:0] code);
        @(posedge clk);
        strap <= code;
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    // strobes: mode write, emulation write, debug enable, debug activate
    task automatic poke(input logic [3:0] s, input logic [2:0] md, input logic ed);
        @(posedge clk);
        {mode_wr, emul_wr, bdm_enable_cmd, bdm_activate} <= s;
        mode_wdata <= md;
        emul_wdata <= ed;
        @(posedge clk);
        {mode_wr, emul_wr, bdm_enable_cmd, bdm_activate} <= 4'h0;
        @(negedge clk);
    endtask
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
    initial begin
        logic [2:0] k;
        logic sgl, per, nar;
        rst_n = 1'b0;
        strap = 3'h4;
        {mode_wr, emul_wr, bdm_enable_cmd, bdm_activate, emul_wdata} = 5'h00;
        {xfer_start, xfer_wide} = 2'h0;
        mode_wdata = 3'h0;
        xfer_addr = 16'h0000;
        for (int c = 0; c < 8; c++) begin
            k = 3'(c);
            sgl = !k[1] && !k[0];
            per = k[1] && !k[0];
            nar = !k[1] && k[0];
            start(k);
            check(16'(mode_bits), 16'(k));
            check(16'(cfg.ext_bus), 16'(!sgl));
            check(16'(cfg.narrow_bus), 16'(nar));
            check(16'(cfg.protect), 16'(k[2] && !per));
            check(16'(cfg.core_active), 16'(!per));
            check(16'(port_e_emulation), 16'(!k[2]));
            check(16'(cfg.port_a_use), sgl ? 16'h0000 : 16'h0002);
            check(16'(cfg.port_b_use), sgl ? 16'h0000 : nar ? 16'h0001 : 16'h0002);
            check(16'(cfg.map_port_ab), 16'(sgl));
            check(16'(cfg.map_port_e), 16'(sgl || (!per && k[2])));
            check(16'(periph_master), 16'(per));
            check(16'(background_debug), 16'(k == 3'h0));
            @(posedge clk);
            {xfer_start, xfer_wide} <= 2'h3;
            xfer_addr <= 16'hFFFF;
            @(posedge clk);
            xfer_start <= 1'b0;
            @(negedge clk);
            check(bus_addr, (sgl || per) ? 16'h0000 : 16'hFFFF);
            check(16'(bus_high_byte), 16'(nar));
            @(negedge clk);
            check(bus_addr, (sgl || per || nar) ? 16'h0000 : 16'hFFFF);
            check(16'(bus_high_byte), 16'h0000);
            if (nar) check(hi_addr, 16'hFFFF);
        end
        start(3'h5);
        poke(4'h8, 3'h1, 1'b0);
        check(16'(mode_bits), 16'h0005);
        poke(4'h8, 3'h7, 1'b0);
        check(16'(mode_bits), 16'h0005);
        poke(4'h4, 3'h0, 1'b1);
        check(16'(cfg.map_port_e), 16'h0000);
        poke(4'h4, 3'h0, 1'b0);
        check(16'(port_e_emulation), 16'h0001);
        poke(4'h1, 3'h0, 1'b0);
        check(16'(background_debug), 16'h0000);
        poke(4'h2, 3'h0, 1'b0);
        poke(4'h1, 3'h0, 1'b0);
        check(16'(background_debug), 16'h0001);
        start(3'h1);
        poke(4'h8, 3'h3, 1'b0);
        check(16'(mode_bits), 16'h0001);
        poke(4'h8, 3'h3, 1'b0);
        check(16'(mode_bits), 16'h0003);
        check(16'(cfg.port_b_use), 16'h0002);
        poke(4'h8, 3'h2, 1'b0);
        check(16'(mode_bits), 16'h0003);
        poke(4'h4, 3'h0, 1'b0);
        check(16'(port_e_emulation), 16'h0001);
        poke(4'h4, 3'h0, 1'b0);
        check(16'(port_e_emulation), 16'h0000);
        check(16'(cfg.map_port_e), 16'h0001);
        start(3'h2);
        poke(4'h8, 3'h3, 1'b0);
        poke(4'hB, 3'h3, 1'b0);
        check(16'(mode_bits), 16'h0002);
        check(16'(cfg.core_active), 16'h0000);
        check(16'(background_debug), 16'h0000);
        summarize();
    end
endmodule
bind oms_mode_select oms_mode_select_monitor u_mon (.clk(clk), .rst_n(rst_n),
    .xfer_start(xfer_start), .xfer_wide(xfer_wide), .xfer_addr(xfer_addr),
    .mode_bits(mode_bits), .port_e_emulation(port_e_emulation), .cfg(cfg),
    .background_debug(background_debug), .periph_master(periph_master),
    .bus_addr(bus_addr), .bus_high_byte(bus_high_byte));
